// >>> bench/pwr_regs_props.sv
// Port checker for the two-instance PWM register file.
// Assumes it is bound onto pwr_regs and sees only its ports.
`timescale 1ns/10ps
module pwr_regs_chk
   import pwr_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic [1:0] period_end_i,
   input wire logic [1:0] enable_o,
   input wire logic [1:0] armed_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   a_rdata_idle: assert property (
      !$past(rd_i) |-> rdata_o == 8'h00) else $error("read data not idle");
   a_mirror_unimpl: assert property (
      rd_i && addr_i[7:2] == 6'h10 && addr_i[1:0] != 2'b11
      |=> (rdata_o & ~PWR_MIR_MASK) == 8'h00)
      else $error("mirror spare bits not zero");
   a_control_unimpl: assert property (
      rd_i && addr_i[7:6] == 2'b00 && addr_i[4:0] == PWR_CON
      |=> (rdata_o & ~PWR_CON_MASK) == 8'h00)
      else $error("control spare bits not zero");
   a_unmapped_zero: assert property (
      rd_i && addr_i[7] |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_enable_mirror: assert property (
      (wr_i && addr_i == PWR_EN_MIR) ##1 !wr_i ##1 !wr_i
      |-> enable_o == $past(wdata_i[5:4], 2))
      else $error("enable mirror write lost");
   a_control_enable: assert property (
      (wr_i && addr_i == {3'b001, PWR_CON}) ##1 !wr_i ##1 !wr_i
      |-> enable_o[1] == $past(wdata_i[7], 2))
      else $error("control enable write lost");
   a_arm_rise: assert property (
      $rose(armed_o[0]) |-> $past(wr_i) || $past(wr_i, 2))
      else $error("armed set without write");
   a_arm_fall: assert property (
      $fell(armed_o[0]) |-> $past(period_end_i[0]) || $past(wr_i)
      || $past(period_end_i[0], 2) || $past(wr_i, 2))
      else $error("armed cleared without cause");
endmodule

bind pwr_regs pwr_regs_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .period_end_i(period_end_i),
   .enable_o(enable_o), .armed_o(armed_o));

// >>> bench/tb_pwr_regs.sv
// Self-checking bench for the PWM register file.
// Assumes the port checker is bound in; the bench drives every port.
`timescale 1ns/10ps
module tb_pwr_regs
   import pwr_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [1:0] period_end_i = 2'b00;
   logic [1:0] trigger_i = 2'b00;
   logic [1:0] out_i = 2'b00;
   logic [1:0] tmr_inc_i = 2'b00;
   logic [7:0] rdata_o;
   logic [1:0] enable_o;
   logic [1:0] armed_o;
   logic [127:0] active_o;
   logic [31:0] seed = 32'h06bd;
   logic [7:0] mem [2][8];
   int fail_count = 0;
   int checks = 0;
   always #12.5 mclk_i = ~mclk_i;
   pwr_regs u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .period_end_i(period_end_i), .trigger_i(trigger_i), .out_i(out_i),
      .tmr_inc_i(tmr_inc_i), .enable_o(enable_o), .armed_o(armed_o),
      .active_o(active_o));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Active word order as the core expects it
   function automatic logic [63:0] act(input int i);
      return {mem[i][7], mem[i][6], mem[i][1], mem[i][0],
         mem[i][3], mem[i][2], mem[i][5], mem[i][4]};
   endfunction
   function automatic logic [7:0] ra(input int i, input logic [4:0] r);
      return (i == 1 ? PWR_INST_STRIDE : PWR_INST0_BASE) | {3'b000, r};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   task automatic pend(input logic [1:0] m);
      @(posedge mclk_i);
      period_end_i <= m;
      @(posedge mclk_i);
      period_end_i <= 2'b00;
      repeat (3) @(posedge mclk_i);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         tmr_inc_i <= 2'b01;
      end
      @(posedge mclk_i);
      tmr_inc_i <= 2'b00;
   endtask
   task automatic close_out();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
   initial begin
      int i;
      int k;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 2; i++) begin
         rd(ra(i, PWR_TML), 8'h00);
         rd(ra(i, PWR_TMH), 8'h00);
      end
      rd(PWR_EN_MIR, 8'h00);
      rd(PWR_LD_MIR, 8'h00);
      rd(PWR_OUT_MIR, 8'h00);
      rd(8'h80, 8'h00);
      for (i = 0; i < 2; i++) begin
         for (k = 0; k < 8; k++) begin
            seed = xs(seed);
            trigger_i <= seed[9:8];
            mem[i][k] = (k == 4 + i) ? 8'hff : seed[7:0];
            wr(ra(i, 5'(k)), mem[i][k]);
         end
         wr(ra(i, PWR_TML), 8'h5a);
         wr(ra(i, PWR_TMH), 8'ha5);
      end
      rd(ra(1, PWR_TML), 8'h5a);
      rd(ra(0, PWR_TMH), 8'ha5);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 2; i++) begin
         for (k = 0; k < 8; k++) begin
            rd(ra(i, 5'(k)), mem[i][k]);
         end
         rd(ra(i, PWR_TML), 8'h00);
         rd(ra(i, PWR_TMH), 8'h00);
      end
      @(posedge mclk_i);
      out_i <= 2'b10;
      wr(PWR_EN_MIR, 8'hff);
      rd(PWR_EN_MIR, 8'h30);
      chk(enable_o, 2'b11);
      rd(ra(0, PWR_CON), 8'h80);
      rd(ra(1, PWR_CON), 8'ha0);
      rd(PWR_OUT_MIR, 8'h20);
      wr(PWR_EN_MIR, 8'h00);
      wr(ra(1, PWR_CON), 8'hff);
      rd(ra(1, PWR_CON), 8'hbc);
      rd(PWR_EN_MIR, 8'h20);
      wr(ra(1, PWR_CON), 8'h00);
      wr(PWR_LD_MIR, 8'h10);
      rd(ra(0, PWR_LDC), 8'h80);
      rd(PWR_LD_MIR, 8'h10);
      chk(armed_o, 2'b01);
      pend(2'b01);
      chk(active_o[63:0], act(0));
      rd(PWR_LD_MIR, 8'h00);
      wr(ra(1, PWR_LDC), 8'h80);
      rd(PWR_LD_MIR, 8'h20);
      pend(2'b10);
      chk(active_o[127:64], act(1));
      // Arm then cancel: a later period end must not load the new byte
      wr(ra(1, PWR_PRL), ~mem[1][4]);
      wr(ra(1, PWR_LDC), 8'h80);
      wr(ra(1, PWR_LDC), 8'h00);
      pend(2'b10);
      rd(PWR_LD_MIR, 8'h00);
      chk(active_o[127:64], act(1));
      // Trigger-gated load waits for a trigger inside the period
      @(posedge mclk_i);
      trigger_i <= 2'b00;
      wr(ra(0, PWR_DCL), ~mem[0][2]);
      wr(ra(0, PWR_LDC), 8'hc0);
      pend(2'b01);
      chk(active_o[63:0], act(0));
      rd(PWR_LD_MIR, 8'h10);
      mem[0][2] = ~mem[0][2];
      @(posedge mclk_i);
      trigger_i <= 2'b01;
      @(posedge mclk_i);
      trigger_i <= 2'b00;
      pend(2'b01);
      chk(active_o[63:0], act(0));
      rd(PWR_LD_MIR, 8'h00);
      // Timer counts enabled pulses and carries into the high byte
      wr(ra(0, PWR_CON), 8'h80);
      wr(ra(0, PWR_TML), 8'hff);
      wr(ra(0, PWR_TMH), 8'h12);
      tick(3);
      rd(ra(0, PWR_TML), 8'h02);
      rd(ra(0, PWR_TMH), 8'h13);
      wr(ra(0, PWR_CLK), 8'h10);
      tick(4);
      rd(ra(0, PWR_TML), 8'h04);
      close_out();
   end
endmodule

// >>> src/pwr_pkg.sv
// Package for the two-instance 16-bit PWM register interface.
// Assumes byte-wide register port with 8-bit word addresses.
package pwr_pkg;
   localparam int PWR_NINST = 2;
   // Per-instance register block: base + index
   localparam logic [7:0] PWR_INST_STRIDE = 8'h20;
   localparam logic [7:0] PWR_INST0_BASE = 8'h00;
   localparam logic [4:0] PWR_PHL = 5'h00;
   localparam logic [4:0] PWR_PHH = 5'h01;
   localparam logic [4:0] PWR_DCL = 5'h02;
   localparam logic [4:0] PWR_DCH = 5'h03;
   localparam logic [4:0] PWR_PRL = 5'h04;
   localparam logic [4:0] PWR_PRH = 5'h05;
   localparam logic [4:0] PWR_OFL = 5'h06;
   localparam logic [4:0] PWR_OFH = 5'h07;
   localparam logic [4:0] PWR_TML = 5'h08;
   localparam logic [4:0] PWR_TMH = 5'h09;
   localparam logic [4:0] PWR_CON = 5'h0a;
   localparam logic [4:0] PWR_INTE = 5'h0b;
   localparam logic [4:0] PWR_INTF = 5'h0c;
   localparam logic [4:0] PWR_CLK = 5'h0d;
   localparam logic [4:0] PWR_LDC = 5'h0e;
   localparam logic [4:0] PWR_OFC = 5'h0f;
   // Shared mirror registers
   localparam logic [7:0] PWR_EN_MIR = 8'h40;
   localparam logic [7:0] PWR_LD_MIR = 8'h41;
   localparam logic [7:0] PWR_OUT_MIR = 8'h42;
   // Field positions
   localparam int PWR_CON_EN = 7;
   localparam int PWR_CON_OUT = 5;
   localparam int PWR_LDC_ARM = 7;
   localparam int PWR_MIR_LSB = 4;
   localparam int PWR_CLK_PS = 4;
   // Implemented-bit masks
   localparam logic [7:0] PWR_CON_MASK = 8'hbc;
   localparam logic [7:0] PWR_INT_MASK = 8'h0f;
   localparam logic [7:0] PWR_CLK_MASK = 8'h73;
   localparam logic [7:0] PWR_LDC_MASK = 8'hc1;
   localparam logic [7:0] PWR_OFC_MASK = 8'h71;
   localparam logic [7:0] PWR_MIR_MASK = 8'h30;
   localparam logic [7:0] PWR_RST_BYTE = 8'h00;
endpackage

// >>> src/pwr_regs.sv
// Register file of a two-instance 16-bit PWM: counts, timer, control
// and shared mirror registers. The counting core sits outside and
// talks through timer increment, period end, trigger and active values.
// Assumes a byte register port with one-cycle read latency.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/10ps

// Operation
// - Period count held as low byte bits 7:0 and high byte bits 15:8.
// - Offset count split into readable writable high and low bytes.
// - Timer count bytes readable, writable, cleared on every reset.
// - Enable mirror shows instance enables at bits 4 and 5, reset zero.
// - Load mirror shows reload-armed bits at 5:4, equal to source.
// - Output mirror bits 5:4 match each control register output bit.
// - Unimplemented mirror and control bits read zero, writes ignored.
// - Period and offset counts not reset; keep contents on reset.
// - Armed and untriggered: load buffers into active at period end.
// - Hardware clears armed bit after reload; software may clear it.
module pwr_regs
   import pwr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // PWM core side, one lane per instance
   input wire logic [1:0] period_end_i,
   input wire logic [1:0] trigger_i,
   input wire logic [1:0] out_i,
   input wire logic [1:0] tmr_inc_i,
   output logic [1:0] enable_o,
   output logic [1:0] armed_o,
   output logic [127:0] active_o
);
   logic [7:0] ph_lo_ff [PWR_NINST];
   logic [7:0] ph_hi_ff [PWR_NINST];
   logic [7:0] dc_lo_ff [PWR_NINST];
   logic [7:0] dc_hi_ff [PWR_NINST];
   logic [7:0] pr_lo_ff [PWR_NINST];
   logic [7:0] pr_hi_ff [PWR_NINST];
   logic [7:0] of_lo_ff [PWR_NINST];
   logic [7:0] of_hi_ff [PWR_NINST];
   logic [15:0] tmr_ff [PWR_NINST];
   logic [7:0] con_ff [PWR_NINST];
   logic [7:0] inte_ff [PWR_NINST];
   logic [7:0] intf_ff [PWR_NINST];
   logic [7:0] clk_ff [PWR_NINST];
   logic [7:0] ldc_ff [PWR_NINST];
   logic [7:0] ofc_ff [PWR_NINST];
   logic [1:0] armed;
   logic [63:0] active [PWR_NINST];
   logic [7:0] inst_rd [PWR_NINST];
   logic [7:0] nxt_rdata;
   logic [1:0] en_bits;
   logic [1:0] out_bits;
   logic wr_en_mir;
   logic wr_ld_mir;
   logic wr_out_mir;
   logic [1:0] mir_w;

   assign wr_en_mir = wr_i & (addr_i == PWR_EN_MIR);
   assign wr_ld_mir = wr_i & (addr_i == PWR_LD_MIR);
   assign wr_out_mir = wr_i & (addr_i == PWR_OUT_MIR);
   assign mir_w = wdata_i[PWR_MIR_LSB+1:PWR_MIR_LSB];

   genvar g;
   generate
      for (g = 0; g < PWR_NINST; g++) begin : g_inst
         localparam logic [7:0] BASE = PWR_INST0_BASE
            + 8'(g) * PWR_INST_STRIDE;
         logic hit;
         logic [4:0] idx;
         logic wsel;
         logic ld_arm_wr;
         logic ld_arm_val;
         logic [6:0] pre_cnt_ff;
         logic [6:0] pre_mask;
         logic tmr_tick;

         assign hit = (addr_i[7:5] == BASE[7:5]);
         assign idx = addr_i[4:0];
         assign wsel = wr_i & hit;
         assign ld_arm_wr = (wsel & (idx == PWR_LDC)) | wr_ld_mir;
         assign ld_arm_val = wr_ld_mir ? mir_w[g] : wdata_i[PWR_LDC_ARM];

         // Timer steps once every 2^PS increment pulses; the divider
         // phase restarts whenever the instance is disabled
         assign pre_mask = 7'((8'h01 << clk_ff[g][PWR_CLK_PS+2:PWR_CLK_PS])
            - 8'h01);
         assign tmr_tick = tmr_inc_i[g]
            & ((pre_cnt_ff & pre_mask) == pre_mask);

         always_ff @(posedge mclk_i) begin
            if (rst_i | ~con_ff[g][PWR_CON_EN]) begin
               pre_cnt_ff <= 7'h00;
            end else if (tmr_inc_i[g]) begin
               pre_cnt_ff <= pre_cnt_ff + 7'h01;
            end
         end

         // Count buffers keep contents through reset
         always_ff @(posedge mclk_i) begin
            if (wsel) begin
               unique case (idx)
                  PWR_PHL: ph_lo_ff[g] <= wdata_i;
                  PWR_PHH: ph_hi_ff[g] <= wdata_i;
                  PWR_DCL: dc_lo_ff[g] <= wdata_i;
                  PWR_DCH: dc_hi_ff[g] <= wdata_i;
                  PWR_PRL: pr_lo_ff[g] <= wdata_i;
                  PWR_PRH: pr_hi_ff[g] <= wdata_i;
                  PWR_OFL: of_lo_ff[g] <= wdata_i;
                  PWR_OFH: of_hi_ff[g] <= wdata_i;
                  default: ;
               endcase
            end
         end

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               tmr_ff[g] <= {PWR_RST_BYTE, PWR_RST_BYTE};
            end else if (wsel & (idx == PWR_TML)) begin
               tmr_ff[g][7:0] <= wdata_i;
            end else if (wsel & (idx == PWR_TMH)) begin
               tmr_ff[g][15:8] <= wdata_i;
            end else if (tmr_tick & con_ff[g][PWR_CON_EN]) begin
               tmr_ff[g] <= tmr_ff[g] + 16'h0001;
            end
         end

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               con_ff[g] <= PWR_RST_BYTE;
            end else begin
               if (wsel & (idx == PWR_CON)) begin
                  con_ff[g] <= wdata_i & PWR_CON_MASK;
               end
               if (wr_en_mir) begin
                  con_ff[g][PWR_CON_EN] <= mir_w[g];
               end
               // Output bit follows the core unless software writes it
               if (wr_out_mir) begin
                  con_ff[g][PWR_CON_OUT] <= mir_w[g];
               end else if (!(wsel & (idx == PWR_CON))) begin
                  con_ff[g][PWR_CON_OUT] <= out_i[g];
               end
            end
         end

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               inte_ff[g] <= PWR_RST_BYTE;
               clk_ff[g] <= PWR_RST_BYTE;
               ldc_ff[g] <= PWR_RST_BYTE;
               ofc_ff[g] <= PWR_RST_BYTE;
            end else if (wsel) begin
               unique case (idx)
                  PWR_INTE: inte_ff[g] <= wdata_i & PWR_INT_MASK;
                  PWR_CLK: clk_ff[g] <= wdata_i & PWR_CLK_MASK;
                  PWR_LDC: ldc_ff[g] <= wdata_i & PWR_LDC_MASK;
                  PWR_OFC: ofc_ff[g] <= wdata_i & PWR_OFC_MASK;
                  default: ;
               endcase
            end
         end

         // Flags forced clear while disabled; events win over a clear
         always_ff @(posedge mclk_i) begin
            if (rst_i | ~con_ff[g][PWR_CON_EN]) begin
               intf_ff[g] <= PWR_RST_BYTE;
            end else begin
               if (wsel & (idx == PWR_INTF)) begin
                  intf_ff[g] <= wdata_i & PWR_INT_MASK;
               end
               if (period_end_i[g]) begin
                  intf_ff[g][0] <= 1'b1;
               end
            end
         end

         pwr_reload u_reload (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .arm_wr_i(ld_arm_wr),
            .arm_val_i(ld_arm_val),
            .on_trigger_i(ldc_ff[g][PWR_LDC_ARM-1]),
            .trigger_i(trigger_i[g]),
            .period_end_i(period_end_i[g]),
            .buf_i({of_hi_ff[g], of_lo_ff[g], ph_hi_ff[g], ph_lo_ff[g],
                    dc_hi_ff[g], dc_lo_ff[g], pr_hi_ff[g], pr_lo_ff[g]}),
            .armed_o(armed[g]),
            .active_o(active[g])
         );

         assign en_bits[g] = con_ff[g][PWR_CON_EN];
         assign out_bits[g] = con_ff[g][PWR_CON_OUT];

         always_comb begin
            unique case (idx)
               PWR_PHL: inst_rd[g] = ph_lo_ff[g];
               PWR_PHH: inst_rd[g] = ph_hi_ff[g];
               PWR_DCL: inst_rd[g] = dc_lo_ff[g];
               PWR_DCH: inst_rd[g] = dc_hi_ff[g];
               PWR_PRL: inst_rd[g] = pr_lo_ff[g];
               PWR_PRH: inst_rd[g] = pr_hi_ff[g];
               PWR_OFL: inst_rd[g] = of_lo_ff[g];
               PWR_OFH: inst_rd[g] = of_hi_ff[g];
               PWR_TML: inst_rd[g] = tmr_ff[g][7:0];
               PWR_TMH: inst_rd[g] = tmr_ff[g][15:8];
               PWR_CON: inst_rd[g] = con_ff[g];
               PWR_INTE: inst_rd[g] = inte_ff[g];
               PWR_INTF: inst_rd[g] = intf_ff[g];
               PWR_CLK: inst_rd[g] = clk_ff[g];
               // Armed bit lives in the reload module
               PWR_LDC: inst_rd[g] = {armed[g], ldc_ff[g][6:0]};
               PWR_OFC: inst_rd[g] = ofc_ff[g];
               default: inst_rd[g] = 8'h00;
            endcase
         end
      end
   endgenerate

   always_comb begin
      nxt_rdata = 8'h00;
      if (addr_i == PWR_EN_MIR) begin
         nxt_rdata = {2'h0, en_bits, 4'h0};
      end else if (addr_i == PWR_LD_MIR) begin
         nxt_rdata = {2'h0, armed, 4'h0};
      end else if (addr_i == PWR_OUT_MIR) begin
         nxt_rdata = {2'h0, out_bits, 4'h0};
      end else if (addr_i[7:5] == PWR_INST0_BASE[7:5]) begin
         nxt_rdata = inst_rd[0];
      end else if (addr_i[7:5] == 3'(PWR_INST_STRIDE[7:5])) begin
         nxt_rdata = inst_rd[1];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= nxt_rdata;
      end else begin
         rdata_o <= 8'h00;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         enable_o <= 2'h0;
         armed_o <= 2'h0;
      end else begin
         enable_o <= en_bits;
         armed_o <= armed;
      end
   end

   always_ff @(posedge mclk_i) begin
      active_o <= {active[1], active[0]};
   end
endmodule

// >>> src/pwr_reload.sv
// Reload-arm handling for one instance: holds the armed bit and
// copies buffered values into active registers at period end.
// Assumes period_end_i is a one-cycle pulse from the PWM core.
`timescale 1ns/10ps
module pwr_reload
   import pwr_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control
   input wire logic arm_wr_i,
   input wire logic arm_val_i,
   input wire logic on_trigger_i,
   input wire logic trigger_i,
   input wire logic period_end_i,
   input wire logic [63:0] buf_i,
   // Status
   output logic armed_o,
   output logic [63:0] active_o
);
   logic armed_ff;
   logic trig_seen_ff;
   logic load;

   // A trigger in the closing cycle of a period still counts for it
   assign load = armed_ff & period_end_i
      & (~on_trigger_i | trig_seen_ff | trigger_i);
   assign armed_o = armed_ff;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         armed_ff <= 1'b0;
      end else if (load) begin
         armed_ff <= 1'b0;
      end else if (arm_wr_i) begin
         armed_ff <= arm_val_i;
      end
   end

   // Trigger is remembered within the period when it arrives
   always_ff @(posedge mclk_i) begin
      if (rst_i | load | ~armed_ff) begin
         trig_seen_ff <= 1'b0;
      end else if (trigger_i) begin
         trig_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (load) begin
         active_o <= buf_i;
      end
   end
endmodule
